/* File: src/spmc_power_ctrl.sv */
// Contract
// - Power mode comes from global control bits [4:3]: 00,01,10,11.
// - Port control bit 3 powers down that PHY port regardless of mode.
// - Mode field resets to 00, so the chip starts in normal operation.
// - Normal mode keeps clocks, PHYs, MACs and host interface running.
// - Energy detect without cable emits 120 ns pulses once per second.
// - Energy detect sleeps after no energy longer than the go-sleep time.
// - Sleep disables clocks, MACs, host interface; only energy detection stays.
// - Cable energy during sleep returns to the awake energy detect state.
// - Mode 10 stops all clocks and switches off all PHYs and MACs.
// - In soft power-down any host access wakes and resets every register.
// - Power-saving needs autoneg on, no cable, mode 11; clocks stay up.
// - Power-saving turns only the receiver off, back on when activity resumes.
// - Bit 11 of the PHY control register also powers down a port.
module spmc_power_ctrl
    import spmc_pkg::*;
#(
    parameter int unsigned PULSE_PERIOD = PULSE_PERIOD_CYC
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave.
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Cable energy seen by each receiver, asynchronous.
    input wire logic [PHY_PORTS-1:0] cable_energy,
    // Power gates, beacon and internal reset.
    output spmc_pwr_t pwr,
    output logic [PHY_PORTS-1:0] ed_pulse,
    output logic int_rst
);

    // Registers.
    logic [1:0] mode;
    logic [7:0] sleep_time;
    logic [31:0] prescale;
    logic [PHY_PORTS-1:0] port_pdn;
    logic [PHY_PORTS-1:0] port_an;
    logic [PHY_PORTS-1:0] phy_pdn;
    spmc_state_t state;
    spmc_state_t next_state;

    // Energy synchroniser.
    logic [PHY_PORTS-1:0] energy_meta;
    logic [PHY_PORTS-1:0] energy;

    always_ff @(posedge ref_clk)
    begin
        energy_meta <= cable_energy;
        energy <= energy_meta;
    end

    wire any_energy = |energy;

    // Bus decode.
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_global = (paddr == reg_addr(IDX_GLOBAL_CTRL));
    wire hit_sleep = (paddr == reg_addr(IDX_SLEEP_TIME));
    wire hit_prescale = (paddr == reg_addr(IDX_PRESCALE));
    wire hit_status = (paddr == reg_addr(IDX_STATUS));
    wire hit_port = (paddr[ADDR_W-1:2] >= IDX_PORT_CTRL0)
        && (paddr[ADDR_W-1:2] < IDX_PORT_CTRL0 + 6'(PHY_PORTS));
    wire hit_phy = (paddr[ADDR_W-1:2] >= IDX_PHY_CTRL0)
        && (paddr[ADDR_W-1:2] < IDX_PHY_CTRL0 + 6'(PHY_PORTS));
    wire hit_any = (paddr[1:0] == 2'h0)
        && (hit_global || hit_sleep || hit_prescale || hit_status || hit_port || hit_phy);
    wire port_sel = paddr[2];

    // While asleep the host interface is unpowered, so accesses are refused.
    wire host_off = (state == ST_ED_SLEEP);

    // The access that wakes the chip is a dummy: it stores nothing.
    logic wake_txn;
    wire wake_req = setup && (state == ST_PDOWN);
    wire wr_en = access && pwrite && hit_any && !host_off && !wake_txn;

    assign pready = 1'b1;
    assign pslverr = access && !wake_txn && (host_off || !hit_any);

    // Soft power-down wake issues a one-cycle internal reset.
    wire soft_rst = sys_rst || int_rst;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            int_rst <= 1'b0;
            wake_txn <= 1'b0;
        end
        else
        begin
            int_rst <= wake_req;
            if (wake_req)
            begin
                wake_txn <= 1'b1;
            end
            else if (access)
            begin
                wake_txn <= 1'b0;
            end
        end
    end

    // Writable registers.
    always_ff @(posedge ref_clk)
    begin
        if (soft_rst)
        begin
            mode <= MODE_RST;
            sleep_time <= SLEEP_TIME_RST;
            prescale <= PRESCALE_RST;
            port_pdn <= '0;
            port_an <= {PHY_PORTS{PORT_AN_RST}};
            phy_pdn <= '0;
        end
        else if (wr_en)
        begin
            if (hit_global)
            begin
                mode <= pwdata[MODE_LSB +: 2];
            end
            if (hit_sleep)
            begin
                sleep_time <= pwdata[7:0];
            end
            if (hit_prescale)
            begin
                prescale <= pwdata;
            end
            if (hit_port)
            begin
                port_pdn[port_sel] <= pwdata[PORT_PDN_BIT];
                port_an[port_sel] <= pwdata[PORT_AN_BIT];
            end
            if (hit_phy)
            begin
                phy_pdn[port_sel] <= pwdata[PHY_PDN_BIT];
            end
        end
    end

    // Power-saving is decided per port from autoneg, energy and mode.
    wire [PHY_PORTS-1:0] psave = (mode == PM_SAVE && state == ST_RUN)
        ? (port_an & ~energy) : '0;

    // Read data is captured in the setup cycle and stands in the access cycle.
    logic [DATA_W-1:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        if (host_off || state == ST_PDOWN)
        begin
            rd_mux = '0;
        end
        else if (hit_global)
        begin
            rd_mux[MODE_LSB +: 2] = mode;
        end
        else if (hit_sleep)
        begin
            rd_mux[7:0] = sleep_time;
        end
        else if (hit_prescale)
        begin
            rd_mux = prescale;
        end
        else if (hit_status)
        begin
            rd_mux[STAT_STATE_LSB +: 2] = state;
            rd_mux[STAT_ENERGY_LSB +: PHY_PORTS] = energy;
            rd_mux[STAT_SAVE_LSB +: PHY_PORTS] = psave;
        end
        else if (hit_port)
        begin
            rd_mux[PORT_PDN_BIT] = port_pdn[port_sel];
            rd_mux[PORT_AN_BIT] = port_an[port_sel];
        end
        else if (hit_phy)
        begin
            rd_mux[PHY_PDN_BIT] = phy_pdn[port_sel];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            prdata <= '0;
        end
        else if (setup)
        begin
            prdata <= (hit_any && paddr[1:0] == 2'h0) ? rd_mux : '0;
        end
    end

    // Go-sleep timing: ticks run only while awake in energy detect with no energy.
    wire idle_run = (state == ST_ED_AWAKE) && !any_energy;
    logic sleep_tick;
    logic [8:0] idle_cnt;
    wire idle_expired = (idle_cnt > {1'b0, sleep_time});

    spmc_divider #(.CNT_W(32)) u_sleep_div
    (
        .ref_clk(ref_clk),
        .sys_rst(soft_rst),
        .clr(!idle_run),
        .limit(prescale),
        .tick(sleep_tick)
    );

    always_ff @(posedge ref_clk)
    begin
        if (soft_rst || !idle_run)
        begin
            idle_cnt <= '0;
        end
        else if (sleep_tick && !idle_expired)
        begin
            idle_cnt <= idle_cnt + 9'h001;
        end
    end

    // Mode field mapped onto a resting state.
    function automatic spmc_state_t mode_state(input logic [1:0] m);
        if (m == PM_ENERGY)
        begin
            return ST_ED_AWAKE;
        end
        else if (m == PM_SOFT_PDN)
        begin
            return ST_PDOWN;
        end
        return ST_RUN;
    endfunction

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                next_state = mode_state(mode);
            end
            ST_ED_AWAKE:
            begin
                if (mode != PM_ENERGY)
                begin
                    next_state = mode_state(mode);
                end
                else if (idle_expired)
                begin
                    next_state = ST_ED_SLEEP;
                end
            end
            ST_ED_SLEEP:
            begin
                if (any_energy)
                begin
                    next_state = ST_ED_AWAKE;
                end
            end
            default:
            begin
                next_state = ST_PDOWN;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (soft_rst)
        begin
            state <= ST_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Beacon: while in energy detect, a period divider launches each pulse.
    wire in_ed = (state == ST_ED_AWAKE) || (state == ST_ED_SLEEP);
    logic beacon_tick;
    logic [7:0] pulse_cnt;

    spmc_divider #(.CNT_W(32)) u_beacon_div
    (
        .ref_clk(ref_clk),
        .sys_rst(soft_rst),
        .clr(!in_ed),
        .limit(32'(PULSE_PERIOD - 1)),
        .tick(beacon_tick)
    );

    always_ff @(posedge ref_clk)
    begin
        if (soft_rst || !in_ed)
        begin
            pulse_cnt <= '0;
        end
        else if (beacon_tick)
        begin
            pulse_cnt <= 8'(PULSE_CYC);
        end
        else if (pulse_cnt != 8'h00)
        begin
            pulse_cnt <= pulse_cnt - 8'h01;
        end
    end

    // A port with energy on its cable needs no beacon.
    wire pulse_on = (pulse_cnt != 8'h00);

    // Power gates, registered so the rails never see decode glitches.
    wire core_on = (state == ST_RUN) || (state == ST_ED_AWAKE);
    wire [PHY_PORTS-1:0] port_off = port_pdn | phy_pdn;
    spmc_pwr_t next_pwr;

    always_comb
    begin
        next_pwr.pll_clk_en = core_on;
        next_pwr.host_if_en = core_on;
        next_pwr.mac_en = core_on ? ~port_off : '0;
        next_pwr.phy_tx_en = core_on ? ~port_off : '0;
        next_pwr.phy_rx_en = core_on ? (~port_off & ~psave) : '0;
        next_pwr.energy_det_en = (state == ST_PDOWN) ? '0 : ~port_off;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pwr <= '0;
            ed_pulse <= '0;
        end
        else
        begin
            pwr <= next_pwr;
            ed_pulse <= pulse_on ? (~energy & ~port_off) : '0;
        end
    end

    // Checks.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] hi_run;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !pulse_on)
        begin
            hi_run <= '0;
        end
        else
        begin
            hi_run <= hi_run + 8'h01;
        end
    end

    sequence wake_seq;
        int_rst ##1 (state == ST_RUN && mode == PM_NORMAL);
    endsequence

    a_mode_write: assert property (access && pwrite && hit_global && !host_off && !wake_txn
        |=> mode == $past(pwdata[MODE_LSB +: 2])) else $error("mode field not stored");
    a_mode_after_reset: assert property ($fell(sys_rst) |-> mode == PM_NORMAL
        && state == ST_RUN) else $error("mode not normal after reset");
    a_normal_gates: assert property (state == ST_RUN && mode == PM_NORMAL ##1 state == ST_RUN
        |=> pwr.pll_clk_en && pwr.host_if_en) else $error("normal mode gates off");
    a_port_pdn: assert property (port_off[0] && state != ST_PDOWN
        |=> !pwr.mac_en[0] && !pwr.phy_tx_en[0] && !pwr.phy_rx_en[0]) else $error("port on");
    // The run counter still holds the full width at the edge where the pulse is seen low.
    a_pulse_width: assert property ($fell(pulse_on) && in_ed
        |-> hi_run == 8'(PULSE_CYC)) else $error("beacon pulse width wrong");
    a_sleep_entry: assert property (state == ST_ED_AWAKE && mode == PM_ENERGY
        && idle_expired |=> state == ST_ED_SLEEP) else $error("no sleep after idle timeout");
    a_sleep_gates: assert property (state == ST_ED_SLEEP ##1 state == ST_ED_SLEEP
        |-> !pwr.pll_clk_en && !pwr.host_if_en && pwr.mac_en == '0) else $error("sleep leak");
    a_sleep_wake: assert property (state == ST_ED_SLEEP && any_energy
        |=> state == ST_ED_AWAKE ##1 pwr.pll_clk_en) else $error("no wake on energy");
    a_pdown_gates: assert property (state == ST_PDOWN ##1 state == ST_PDOWN
        |-> !pwr.pll_clk_en && pwr.phy_tx_en == '0 && pwr.mac_en == '0) else $error("pdown leak");
    a_pdown_wake: assert property (wake_req |=> wake_seq) else $error("no wake reset");
    a_save_rx_off: assert property (psave[0] && !port_off[0]
        |=> !pwr.phy_rx_en[0] && pwr.phy_tx_en[0] && pwr.pll_clk_en) else $error("save gates");

endmodule

/* File: src/spmc_pkg.sv */
package spmc_pkg;

    // Two copper PHY ports sit behind this controller.
    localparam int PHY_PORTS = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_GLOBAL_CTRL = 6'h0e;
    localparam logic [5:0] IDX_SLEEP_TIME = 6'h0f;
    localparam logic [5:0] IDX_PORT_CTRL0 = 6'h10;
    localparam logic [5:0] IDX_PHY_CTRL0 = 6'h12;
    localparam logic [5:0] IDX_PRESCALE = 6'h14;
    localparam logic [5:0] IDX_STATUS = 6'h15;

    // Field positions.
    localparam int MODE_LSB = 3;
    localparam int PORT_PDN_BIT = 3;
    localparam int PORT_AN_BIT = 7;
    localparam int PHY_PDN_BIT = 11;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_ENERGY_LSB = 2;
    localparam int STAT_SAVE_LSB = 4;

    // Values after reset.
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [7:0] SLEEP_TIME_RST = 8'h10;
    localparam logic [31:0] PRESCALE_RST = 32'h00030d3f;
    localparam logic PORT_AN_RST = 1'b1;

    // Timing of the energy detect beacon.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PULSE_WIDTH_NS = 120;
    localparam longint PULSE_PERIOD_MS = 1000;
    localparam int PULSE_CYC = (PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_PERIOD_CYC = int'(PULSE_PERIOD_MS * 64'd1000000000 / CLK_PERIOD_PS);

    typedef enum logic [1:0]
    {
        PM_NORMAL = 2'h0,
        PM_ENERGY = 2'h1,
        PM_SOFT_PDN = 2'h2,
        PM_SAVE = 2'h3
    } spmc_mode_t;

    // Gray order along normal, energy detect awake, energy detect asleep.
    typedef enum logic [1:0]
    {
        ST_RUN = 2'h0,
        ST_ED_AWAKE = 2'h1,
        ST_ED_SLEEP = 2'h3,
        ST_PDOWN = 2'h2
    } spmc_state_t;

    typedef struct packed
    {
        logic pll_clk_en;
        logic host_if_en;
        logic [PHY_PORTS-1:0] mac_en;
        logic [PHY_PORTS-1:0] phy_tx_en;
        logic [PHY_PORTS-1:0] phy_rx_en;
        logic [PHY_PORTS-1:0] energy_det_en;
    } spmc_pwr_t;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
        return {idx, 2'h0};
    endfunction

endpackage

/* File: src/spmc_divider.sv */
module spmc_divider
    import spmc_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Control.
    input wire logic clr,
    input wire logic [CNT_W-1:0] limit,
    // Enable pulse, one cycle every limit plus one cycles.
    output logic tick
);

    logic [CNT_W-1:0] count;
    wire at_limit = (count >= limit);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clr)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count <= at_limit ? '0 : count + 1'b1;
            tick <= at_limit;
        end
    end

endmodule

/* File: sim/spmc_host_model.sv */
module spmc_host_model
    import spmc_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // APB master side.
    output logic [ADDR_W-1:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [DATA_W-1:0] pwdata,
    input wire logic pready
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end

    // Released address and data lines carry the inverse of the last value, so a slave that samples late sees junk.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the bench's own timeout ends a wait that never sees pready.
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

/* File: sim/switch_power_mode_control_test.sv */
module switch_power_mode_control_test;
    import spmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PP = 200;
    logic ref_clk;
    logic sys_rst;
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [PHY_PORTS-1:0] cable_energy;
    spmc_pwr_t pwr;
    logic [PHY_PORTS-1:0] ed_pulse;
    logic int_rst;
    int n_fail;
    int checked;
    int n_rst;
    int cyc;
    int n;
    int seed;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [31:0] v;

    spmc_power_ctrl #(.PULSE_PERIOD(PP)) spmc_power_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cable_energy(cable_energy),
        .pwr(pwr), .ed_pulse(ed_pulse), .int_rst(int_rst));

    spmc_host_model spmc_host_model_i (.ref_clk(ref_clk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        checked++;
        if (s !== ex)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, ex, s);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        spmc_host_model_i.xfer(1'b1, {i, 2'h0}, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic er);
        exp_q.push_back({er, ex});
        spmc_host_model_i.xfer(1'b0, a, 32'h0);
    endtask

    task automatic wait_pwr(input logic [9:0] ex, input int lim);
        int k;
        k = 0;
        while (pwr !== ex && k < lim)
        begin
            @(posedge ref_clk);
            k++;
        end
        chk("pwr", {22'h0, ex}, {22'h0, pwr});
    endtask

    // Read results are judged where they appear, against the oldest note.
    always @(posedge ref_clk)
    begin
        cyc++;
        if (int_rst === 1'b1)
            n_rst++;
        if (psel === 1'b1 && penable === 1'b1)
            chk("pready", 32'h1, {31'h0, pready});
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h0;
            chk("prdata", e[31:0], prdata);
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        end
        if (cyc > 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    initial
    begin
        n_fail = 0;
        checked = 0;
        n_rst = 0;
        cyc = 0;
        seed = 32'h9f12;
        sys_rst = 1'b1;
        cable_energy = 2'b11;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h38, 32'h0, 1'b0);
        rd(8'h3c, {24'h0, SLEEP_TIME_RST}, 1'b0);
        rd(8'h50, PRESCALE_RST, 1'b0);
        rd(8'h40, 32'h80, 1'b0);
        rd(8'hfc, 32'h0, 1'b1);
        rd(8'h39, 32'h0, 1'b1);
        wait_pwr(10'h3ff, 10);
        rd(8'h54, 32'h0c, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            v = $random(seed);
            wr(IDX_PRESCALE, v);
            rd(8'h50, v, 1'b0);
            wr(IDX_SLEEP_TIME, v);
            rd(8'h3c, {24'h0, v[7:0]}, 1'b0);
        end
        wr(IDX_PORT_CTRL0, 32'h88);
        wait_pwr(10'b1110101010, 10);
        wr(IDX_PORT_CTRL0, 32'h80);
        wr(IDX_PHY_CTRL0 + 6'h1, 32'h800);
        wait_pwr(10'b1101010101, 10);
        wr(IDX_PHY_CTRL0 + 6'h1, 32'h0);
        wait_pwr(10'h3ff, 10);
        cable_energy <= 2'b10;
        wr(IDX_GLOBAL_CTRL, 32'h18);
        wait_pwr(10'b1111111011, 10);
        rd(8'h54, 32'h18, 1'b0);
        rd(8'h38, 32'h18, 1'b0);
        cable_energy <= 2'b11;
        wait_pwr(10'h3ff, 10);
        wr(IDX_GLOBAL_CTRL, 32'h0);
        wr(IDX_PRESCALE, 32'h3);
        wr(IDX_SLEEP_TIME, 32'h2);
        cable_energy <= 2'b00;
        wr(IDX_GLOBAL_CTRL, 32'h08);
        wait_pwr(10'b0000000011, 60);
        rd(8'h54, 32'h0, 1'b1);
        n = 0;
        while (ed_pulse[0] !== 1'b1 && n < 2 * PP + 40)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("ed_pulse", 32'h3, {30'h0, ed_pulse});
        n = 0;
        while (ed_pulse[0] === 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("pulse width", PULSE_CYC, n);
        while (ed_pulse[0] !== 1'b1 && n < 2 * PP)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("pulse period", PP, n);
        cable_energy <= 2'b01;
        n = 0;
        while (pwr.pll_clk_en !== 1'b1 && n < 10)
        begin
            @(posedge ref_clk);
            n++;
        end
        rd(8'h54, 32'h05, 1'b0);
        cable_energy <= 2'b11;
        wr(IDX_GLOBAL_CTRL, 32'h0);
        wr(IDX_SLEEP_TIME, 32'h55);
        wr(IDX_GLOBAL_CTRL, 32'h10);
        wait_pwr(10'h000, 10);
        rd(8'h38, 32'h0, 1'b0);
        repeat (3) @(posedge ref_clk);
        chk("int_rst pulses", 32'h1, n_rst);
        rd(8'h3c, {24'h0, SLEEP_TIME_RST}, 1'b0);
        rd(8'h38, 32'h0, 1'b0);
        wait_pwr(10'h3ff, 10);
        repeat (3) @(posedge ref_clk);
        chk("notes left", 32'h0, exp_q.size());
        print_verdict();
    end
endmodule
